// >>> hw/mac_fc_device.sv
`timescale 1ns/1ps


`include "mac_fc_defs.svh"

module mac_fc_device
   import mac_fc_pkg::*;
#(
   parameter bit PFC_ENABLE = 1'b1,
   parameter bit TX_ONLY = 1'b0
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   mac_fc_if.device fc,
   input wire logic [`FC_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rd_data,
   input wire logic i_rx_pfc_frame,
   input wire queue_mask_type i_rx_quanta_en,
   input wire logic [`FC_QUEUES*`FC_QUANTA_W-1:0] i_rx_quanta,
   output logic o_pause_xon_gen,
   output logic o_pause_xoff_gen,
   output queue_mask_type o_pfc_xon_gen,
   output queue_mask_type o_pfc_xoff_gen,
   output logic o_tx_pause_hold,
   output quanta_type o_tx_pause_quanta
);

   logic [1:0] config_bits;
   pause_req_type sw_cmd;
   pause_req_type pin_cmd;
   pause_req_type next_cmd;
   pause_src_type next_src;
   pause_src_type last_src;
   queue_mask_type rx_flags;
   queue_mask_type next_pfc_xon;
   queue_mask_type next_pfc_xoff;
   logic tx_hold;
   logic tx_load;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Control register is a one-shot command, it never holds a level
   always_comb
   begin
      sw_cmd = '0;
      if (i_wr && i_addr == `FC_REG_CTRL)
      begin
         sw_cmd = i_wr_data[1:0];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         config_bits <= `FC_CONFIG_RESET;
      end
      else if (i_ce && i_wr && i_addr == `FC_REG_CONFIG)
      begin
         config_bits <= i_wr_data[1:0];
      end
   end

   // ----------------------------------------
   // Standard pause arbitration
   // ----------------------------------------
   // Both bits together is contradictory, so nothing is sent
   always_comb
   begin
      pin_cmd = '0;
      if (config_bits[`FC_CFG_PIN_PAUSE_EN])
      begin
         pin_cmd = fc.pause_request_bits;
      end
      next_cmd = '0;
      next_src = SRC_NONE;
      if (sw_cmd != '0)
      begin
         next_cmd = sw_cmd;
         next_src = SRC_REG;
      end
      else if (pin_cmd != '0)
      begin
         next_cmd = pin_cmd;
         next_src = SRC_PIN;
      end
      if (next_cmd == 2'h3)
      begin
         next_cmd = '0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pause_xon_gen <= 1'b0;
         o_pause_xoff_gen <= 1'b0;
         last_src <= SRC_NONE;
      end
      else if (i_ce)
      begin
         o_pause_xon_gen <= next_cmd[`FC_REQ_XON];
         o_pause_xoff_gen <= next_cmd[`FC_REQ_XOFF];
         if (next_src != SRC_NONE)
         begin
            last_src <= next_src;
         end
      end
   end

   // ----------------------------------------
   // Priority requests
   // ----------------------------------------
   always_comb
   begin
      next_pfc_xon = '0;
      next_pfc_xoff = '0;
      for (int k = 0; k < `FC_QUEUES; k++)
      begin
         if (PFC_ENABLE && config_bits[`FC_CFG_PIN_PFC_EN])
         begin
            next_pfc_xon[k] = fc.tx_priority_request_bits[2*k]
               & ~fc.tx_priority_request_bits[2*k+1];
            next_pfc_xoff[k] = fc.tx_priority_request_bits[2*k+1]
               & ~fc.tx_priority_request_bits[2*k];
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pfc_xon_gen <= '0;
         o_pfc_xoff_gen <= '0;
      end
      else if (i_ce)
      begin
         o_pfc_xon_gen <= next_pfc_xon;
         o_pfc_xoff_gen <= next_pfc_xoff;
      end
   end

   // ----------------------------------------
   // Receive priority pause timers
   // ----------------------------------------
   for (genvar n = 0; n < `FC_QUEUES; n++)
   begin : g_rx_queue
      fc_pause_timer u_timer (
         .i_sys_clk(i_sys_clk),
         .i_rst_b(i_rst_b),
         .i_ce(i_ce),
         .i_load(PFC_ENABLE && i_rx_pfc_frame && i_rx_quanta_en[n]),
         .i_quanta(i_rx_quanta[n*`FC_QUANTA_W +: `FC_QUANTA_W]),
         .o_active(rx_flags[n])
      );
   end

   assign fc.rx_priority_pause_flags = rx_flags;

   // ----------------------------------------
   // Transmit-only pause duration
   // ----------------------------------------
   // Other builds never look at the duration bus at all
   assign tx_load = TX_ONLY && fc.tx_pause_duration_valid;

   fc_pause_timer u_tx_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_load(tx_load),
      .i_quanta(fc.tx_pause_duration),
      .o_active(tx_hold)
   );

   assign o_tx_pause_hold = tx_hold;

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_tx_pause_quanta <= '0;
      end
      else if (i_ce && tx_load)
      begin
         o_tx_pause_quanta <= fc.tx_pause_duration;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rd_data <= 32'h0;
      end
      else if (i_ce)
      begin
         o_rd_data <= 32'h0;
         if (i_rd)
         begin
            unique case (i_addr)
               `FC_REG_CONFIG:
               begin
                  o_rd_data <= {30'h0, config_bits};
               end
               `FC_REG_STATUS:
               begin
                  o_rd_data <= {14'h0, last_src, 7'h0, tx_hold, rx_flags};
               end
               default:
               begin
                  o_rd_data <= 32'h0;
               end
            endcase
         end
      end
   end

endmodule // mac_fc_device

// >>> include/mac_fc_defs.svh
`ifndef MAC_FC_DEFS_SVH
`define MAC_FC_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FC_QUEUES 8
`define FC_REQ_W 16
`define FC_QUANTA_W 16
`define FC_TIMER_W 19

// ----------------------------------------
// Request bit positions
// ----------------------------------------
`define FC_REQ_XON 0
`define FC_REQ_XOFF 1

// ----------------------------------------
// Timing
// ----------------------------------------
`define FC_QUANTA_BIT_TIMES 512
`define FC_DATAPATH_BITS 64
`define FC_CYCLES_PER_QUANTA (`FC_QUANTA_BIT_TIMES / `FC_DATAPATH_BITS)

// ----------------------------------------
// Register map
// ----------------------------------------
`define FC_ADDR_W 4
`define FC_REG_CTRL 4'h0
`define FC_REG_CONFIG 4'h4
`define FC_REG_STATUS 4'h8
`define FC_CONFIG_RESET 2'h3
`define FC_CFG_PIN_PAUSE_EN 0
`define FC_CFG_PIN_PFC_EN 1
`define FC_STAT_TX_HOLD 8
`define FC_STAT_SRC_LSB 16

`endif

// >>> include/mac_fc_pkg.sv
`include "mac_fc_defs.svh"

package mac_fc_pkg;

   typedef logic [`FC_QUANTA_W-1:0] quanta_type;
   typedef logic [`FC_QUEUES-1:0] queue_mask_type;
   typedef logic [`FC_REQ_W-1:0] pfc_req_type;
   typedef logic [1:0] pause_req_type;
   typedef enum logic [1:0] {SRC_NONE, SRC_REG, SRC_PIN} pause_src_type;

endpackage

// >>> include/mac_fc_if.sv
`timescale 1ns/1ps

interface mac_fc_if;
   import mac_fc_pkg::*;

   pause_req_type pause_request_bits;
   pfc_req_type tx_priority_request_bits;
   quanta_type tx_pause_duration;
   logic tx_pause_duration_valid;
   queue_mask_type rx_priority_pause_flags;

   modport device (
      input pause_request_bits,
      input tx_priority_request_bits,
      input tx_pause_duration,
      input tx_pause_duration_valid,
      output rx_priority_pause_flags
   );

   modport client (
      output pause_request_bits,
      output tx_priority_request_bits,
      output tx_pause_duration,
      output tx_pause_duration_valid,
      input rx_priority_pause_flags
   );

endinterface

// >>> hw/fc_pause_timer.sv
`timescale 1ns/1ps

`include "mac_fc_defs.svh"

module fc_pause_timer
   import mac_fc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_load,
   input wire quanta_type i_quanta,
   output logic o_active
);

   localparam logic [`FC_TIMER_W-1:0] CYC_PER_QUANTA = `FC_TIMER_W'(`FC_CYCLES_PER_QUANTA);

   logic [`FC_TIMER_W-1:0] remaining;
   logic [`FC_TIMER_W-1:0] next_remaining;

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   // A new load always restarts, so a fresh frame extends or cuts the hold
   always_comb
   begin
      next_remaining = `FC_TIMER_W'(i_quanta) * CYC_PER_QUANTA - `FC_TIMER_W'(1);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         remaining <= '0;
         o_active <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_load && i_quanta != '0)
         begin
            remaining <= next_remaining;
            o_active <= 1'b1;
         end
         else if (i_load)
         begin
            remaining <= '0;
            o_active <= 1'b0;
         end
         else if (remaining != '0)
         begin
            remaining <= remaining - `FC_TIMER_W'(1);
         end
         else
         begin
            o_active <= 1'b0;
         end
      end
   end

endmodule // fc_pause_timer

// >>> hw/mac_fc_client.sv
`timescale 1ns/1ps

`include "mac_fc_defs.svh"

module mac_fc_client
   import mac_fc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   mac_fc_if.client fc,
   input wire logic i_req_xon,
   input wire logic i_req_xoff,
   input wire queue_mask_type i_pfc_xon,
   input wire queue_mask_type i_pfc_xoff,
   input wire quanta_type i_duration,
   input wire logic i_duration_valid,
   output queue_mask_type o_queue_paused
);

   pause_req_type pause_bits;
   pfc_req_type pfc_bits;
   quanta_type duration;
   logic duration_valid;

   // ----------------------------------------
   // Request drive
   // ----------------------------------------
   // Duration is zeroed without valid so stale values never leak
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pause_bits <= '0;
         pfc_bits <= '0;
         duration <= '0;
         duration_valid <= 1'b0;
         o_queue_paused <= '0;
      end
      else if (i_ce)
      begin
         pause_bits <= {i_req_xoff, i_req_xon};
         for (int k = 0; k < `FC_QUEUES; k++)
         begin
            pfc_bits[2*k] <= i_pfc_xon[k];
            pfc_bits[2*k+1] <= i_pfc_xoff[k];
         end
         duration <= i_duration_valid ? i_duration : '0;
         duration_valid <= i_duration_valid;
         o_queue_paused <= fc.rx_priority_pause_flags;
      end
   end

   assign fc.pause_request_bits = pause_bits;
   assign fc.tx_priority_request_bits = pfc_bits;
   assign fc.tx_pause_duration = duration;
   assign fc.tx_pause_duration_valid = duration_valid;

endmodule // mac_fc_client

// >>> verif/mac_fc_properties.sv
`timescale 1ns/1ps

module mac_fc_checker
   import mac_fc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire pause_req_type pause_request_bits,
   input wire pfc_req_type tx_priority_request_bits,
   input wire quanta_type tx_pause_duration,
   input wire logic tx_pause_duration_valid,
   input wire queue_mask_type rx_priority_pause_flags,
   input wire logic i_wr,
   input wire logic o_pause_xon_gen,
   input wire logic o_pause_xoff_gen,
   input wire queue_mask_type o_pfc_xon_gen,
   input wire queue_mask_type o_pfc_xoff_gen,
   input wire logic o_tx_pause_hold
);
   // ----------------------------------------
   // Expected queue requests
   // ----------------------------------------
   queue_mask_type w_on;
   queue_mask_type w_off;
   queue_mask_type q_on;
   queue_mask_type q_off;

   always_comb
   begin
      for (int k = 0; k < 8; k++)
      begin
         w_on[k] = tx_priority_request_bits[2*k] & ~tx_priority_request_bits[2*k+1];
         w_off[k] = tx_priority_request_bits[2*k+1] & ~tx_priority_request_bits[2*k];
      end
   end

   // Registered so it lines up with the device's own sampling edge
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         q_on <= '0;
         q_off <= '0;
      end
      else
      begin
         q_on <= w_on;
         q_off <= w_off;
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   property p_xon_cause;
      o_pause_xon_gen |-> $past(pause_request_bits) == 2'h1 || $past(i_wr);
   endproperty
   property p_xoff_cause;
      o_pause_xoff_gen |-> $past(pause_request_bits) == 2'h2 || $past(i_wr);
   endproperty
   property p_pause_refused;
      pause_request_bits == 2'h3 && !i_wr |=> !o_pause_xon_gen && !o_pause_xoff_gen;
   endproperty
   property p_pfc_on;
      o_pfc_xon_gen == q_on;
   endproperty
   property p_pfc_off;
      o_pfc_xoff_gen == q_off;
   endproperty
   property p_dur_idle;
      !tx_pause_duration_valid |-> tx_pause_duration == 16'h0;
   endproperty
   property p_flag_span;
      $rose(rx_priority_pause_flags[0]) |-> rx_priority_pause_flags[0] [*8];
   endproperty
   property p_hold_span;
      $rose(o_tx_pause_hold) |-> o_tx_pause_hold [*8];
   endproperty

   a_xon_cause: assert property (p_xon_cause) else $error("xon pulse without cause");
   a_xoff_cause: assert property (p_xoff_cause) else $error("xoff pulse without cause");
   a_pause_refused: assert property (p_pause_refused) else $error("pause both bits");
   a_pfc_on: assert property (p_pfc_on) else $error("queue xon pulse wrong");
   a_pfc_off: assert property (p_pfc_off) else $error("queue xoff pulse wrong");
   a_dur_idle: assert property (p_dur_idle) else $error("duration without valid");
   a_flag_span: assert property (p_flag_span) else $error("flag span short");
   a_hold_span: assert property (p_hold_span) else $error("hold span short");

   c_flag: cover property ($rose(rx_priority_pause_flags[0]));
   c_hold: cover property ($rose(o_tx_pause_hold));
   c_pfc: cover property (o_pfc_xon_gen != 8'h0);
endmodule // mac_fc_checker

// >>> verif/tb_top.sv
`timescale 1ns/1ps

`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
   $display("Error %s expected %0h seen %0h", n, e, s); end end

module tb_top
   import mac_fc_pkg::*;
;
   logic i_sys_clk, i_rst_b, i_wr, i_rd, i_rx_pfc_frame, i_req_xon, i_req_xoff;
   logic i_duration_valid, o_pause_xon_gen, o_pause_xoff_gen, o_tx_pause_hold;
   logic i_ce;
   logic [3:0] i_addr;
   logic [31:0] i_wr_data, o_rd_data;
   logic [127:0] i_rx_quanta;
   queue_mask_type i_rx_quanta_en, i_pfc_xon, i_pfc_xoff, o_pfc_xon_gen, o_pfc_xoff_gen;
   queue_mask_type o_queue_paused;
   quanta_type i_duration, o_tx_pause_quanta;
   int n_fail = 0;
   int compares = 0;

   mac_fc_if fc_if();

   mac_fc_device #(.PFC_ENABLE(1'b1), .TX_ONLY(1'b1)) mac_fc_device_inst (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .fc(fc_if),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
      .o_rd_data(o_rd_data), .i_rx_pfc_frame(i_rx_pfc_frame),
      .i_rx_quanta_en(i_rx_quanta_en), .i_rx_quanta(i_rx_quanta),
      .o_pause_xon_gen(o_pause_xon_gen), .o_pause_xoff_gen(o_pause_xoff_gen),
      .o_pfc_xon_gen(o_pfc_xon_gen), .o_pfc_xoff_gen(o_pfc_xoff_gen),
      .o_tx_pause_hold(o_tx_pause_hold), .o_tx_pause_quanta(o_tx_pause_quanta));

   mac_fc_client mac_fc_client_inst (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .fc(fc_if),
      .i_req_xon(i_req_xon), .i_req_xoff(i_req_xoff), .i_pfc_xon(i_pfc_xon),
      .i_pfc_xoff(i_pfc_xoff), .i_duration(i_duration),
      .i_duration_valid(i_duration_valid), .o_queue_paused(o_queue_paused));

   mac_fc_checker mac_fc_checker_inst (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .pause_request_bits(fc_if.pause_request_bits),
      .tx_priority_request_bits(fc_if.tx_priority_request_bits),
      .tx_pause_duration(fc_if.tx_pause_duration),
      .tx_pause_duration_valid(fc_if.tx_pause_duration_valid),
      .rx_priority_pause_flags(fc_if.rx_priority_pause_flags), .i_wr(i_wr),
      .o_pause_xon_gen(o_pause_xon_gen), .o_pause_xoff_gen(o_pause_xoff_gen),
      .o_pfc_xon_gen(o_pfc_xon_gen), .o_pfc_xoff_gen(o_pfc_xoff_gen),
      .o_tx_pause_hold(o_tx_pause_hold));

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_pause;
      @(posedge i_sys_clk) i_req_xon <= 1'b1;
      @(posedge i_sys_clk) i_req_xon <= 1'b0;
      i_req_xoff <= 1'b1;
      @(posedge i_sys_clk) i_req_xon <= 1'b1;
      #1 `CHK("xon", 2'h1, {o_pause_xoff_gen, o_pause_xon_gen})
      @(posedge i_sys_clk) {i_req_xon, i_req_xoff} <= 2'h0;
      #1 `CHK("xoff", 2'h2, {o_pause_xoff_gen, o_pause_xon_gen})
      @(posedge i_sys_clk) #1 `CHK("both", 2'h0, {o_pause_xoff_gen, o_pause_xon_gen})
      // Pin xon meets a register xoff command at the same edge
      @(posedge i_sys_clk) i_req_xon <= 1'b1;
      @(posedge i_sys_clk) i_req_xon <= 1'b0;
      {i_wr, i_addr, i_wr_data} <= {1'b1, 4'h0, 32'h2};
      @(posedge i_sys_clk) i_wr <= 1'b0;
      #1 `CHK("precedence", 2'h2, {o_pause_xoff_gen, o_pause_xon_gen})
      // Pin pause disabled in config, so a pin request is dropped
      @(posedge i_sys_clk) {i_wr, i_addr, i_wr_data} <= {1'b1, 4'h4, 32'h2};
      @(posedge i_sys_clk) {i_wr, i_req_xon} <= 2'h1;
      @(posedge i_sys_clk) {i_wr, i_req_xon, i_wr_data} <= {2'h2, 32'h3};
      @(posedge i_sys_clk) i_wr <= 1'b0;
      #1 `CHK("pin disabled", 1'b0, o_pause_xon_gen)
   endtask

   task t_pfc;
      @(posedge i_sys_clk) {i_pfc_xon, i_pfc_xoff} <= {8'h0F, 8'h18};
      @(posedge i_sys_clk) {i_pfc_xon, i_pfc_xoff} <= 16'h0;
      @(posedge i_sys_clk) #1 `CHK("queue gen", 16'h1007, {o_pfc_xoff_gen, o_pfc_xon_gen})
   endtask

   task frame(input queue_mask_type en, input logic [127:0] q);
      @(posedge i_sys_clk) {i_rx_pfc_frame, i_rx_quanta_en, i_rx_quanta} <= {1'b1, en, q};
      @(posedge i_sys_clk) i_rx_pfc_frame <= 1'b0;
   endtask

   task t_rx;
      int n0, n1, n2, n3;
      {n0, n1, n2, n3} = '0;
      frame(8'h03, 128'h500020001);
      repeat (30)
      begin
         #1 {n0, n1, n2, n3} = {n0 + fc_if.rx_priority_pause_flags[0],
            n1 + fc_if.rx_priority_pause_flags[1], n2 + fc_if.rx_priority_pause_flags[2],
            n3 + o_queue_paused[1]};
         @(posedge i_sys_clk);
      end
      `CHK("flag0 cycles", 8, n0)
      `CHK("flag1 cycles", 16, n1)
      `CHK("flag2 cycles", 0, n2)
      `CHK("paused1 cycles", 16, n3)
      frame(8'h01, 128'h3);
      repeat (10) @(posedge i_sys_clk);
      #1 `CHK("flag0 held", 1'b1, fc_if.rx_priority_pause_flags[0])
      frame(8'h01, 128'h0);
      #1 `CHK("flag0 cleared", 1'b0, fc_if.rx_priority_pause_flags[0])
   endtask

   task t_dur;
      int n;
      n = 0;
      @(posedge i_sys_clk) i_duration <= 16'h9;
      repeat (4) @(posedge i_sys_clk);
      #1 `CHK("ignored hold", 1'b0, o_tx_pause_hold)
      `CHK("ignored quanta", 16'h0, o_tx_pause_quanta)
      @(posedge i_sys_clk) {i_duration, i_duration_valid} <= {16'h2, 1'b1};
      @(posedge i_sys_clk) {i_duration, i_duration_valid} <= 17'h0;
      repeat (30)
      begin
         #1 n += o_tx_pause_hold;
         @(posedge i_sys_clk);
      end
      `CHK("hold cycles", 16, n)
      `CHK("quanta", 16'h2, o_tx_pause_quanta)
      // Clock enable low stretches the hold by the frozen cycles
      @(posedge i_sys_clk) {i_duration, i_duration_valid} <= {16'h1, 1'b1};
      @(posedge i_sys_clk) {i_duration, i_duration_valid} <= 17'h0;
      @(posedge i_sys_clk) i_ce <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_ce <= 1'b1;
      repeat (7) @(posedge i_sys_clk);
      #1 `CHK("frozen hold late", 1'b1, o_tx_pause_hold)
      @(posedge i_sys_clk) #1 `CHK("frozen hold end", 1'b0, o_tx_pause_hold)
   endtask

   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_sys_clk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_sys_clk) i_rd <= 1'b0;
      #1 `CHK("read data", e, o_rd_data)
   endtask

   task complete_run;
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   // Whole sequence needs about 140 cycles
   initial
   begin
      repeat (5000) @(posedge i_sys_clk);
      n_fail++;
      complete_run;
   end

   initial
   begin
      {i_rst_b, i_wr, i_rd, i_rx_pfc_frame, i_req_xon, i_req_xoff, i_duration_valid} = '0;
      {i_addr, i_wr_data, i_rx_quanta, i_rx_quanta_en, i_duration} = '0;
      {i_pfc_xon, i_pfc_xoff} = '0;
      i_ce = 1'b1;
      repeat (20) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      t_pause;
      t_pfc;
      t_rx;
      t_dur;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h3);
      rd(4'hC, 32'h0);
      rd(4'h8, 32'h0001_0000);
      complete_run;
   end
endmodule // tb_top
